/* logic/tss_pkg.sv */
// Constants, field layouts, lookup functions and carrier types of the touch sensor housekeeping block.
`default_nettype none
package tss_pkg;
  // Core clock and the time base that all slow timers count in.
  localparam int CLK_HZ          = 125_000_000;
  localparam int TIME_UNIT_MS    = 100;
  localparam int TICK_CYC_DEF    = CLK_HZ / 1000 * TIME_UNIT_MS;
  localparam int TICK_W          = 24;
  localparam int WD_TIME_MS      = 2000;
  localparam int RST_PULSE_MS    = 100;
  localparam logic [7:0] WD_TICKS        = 8'(WD_TIME_MS / TIME_UNIT_MS);
  localparam logic [7:0] RST_PULSE_TICKS = 8'(RST_PULSE_MS / TIME_UNIT_MS);

  // Register byte offsets.
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_STS_SRC    = 8'h00;
  localparam logic [7:0] OFF_SLEEP_CFG  = 8'h04;
  localparam logic [7:0] OFF_SIGNAL_CFG = 8'h08;
  localparam logic [7:0] OFF_SERIAL_CFG = 8'h0C;
  localparam logic [7:0] OFF_STATE      = 8'h10;
  localparam logic [7:0] OFF_LOW_ERR0   = 8'h14;
  localparam logic [7:0] OFF_LOW_ERR1   = 8'h18;
  localparam logic [7:0] OFF_GAIN_OK0   = 8'h1C;
  localparam logic [7:0] OFF_GAIN_OK1   = 8'h20;

  // Field positions.
  localparam int STS_BIT_RSTHOST = 0;
  localparam int STS_BIT_TOUCH   = 5;
  localparam int STS_BIT_DEBUG   = 7;
  localparam int SDC_LSB         = 0;
  localparam int DH_EN_BIT       = 3;
  localparam int AWAKE_LSB       = 4;
  localparam int DHT_LSB         = 8;
  localparam int LSL_LSB         = 0;
  localparam int GTT_LSB         = 12;
  localparam int SR_LSB          = 0;
  localparam int ST_ASLEEP       = 0;
  localparam int ST_STS_ACTIVE   = 1;
  localparam int ST_SLEEP_ARMED  = 2;
  localparam int ST_WD_ARMED     = 3;
  localparam int ST_DRIFT_HOLD   = 4;
  localparam int ST_DBG_BUSY     = 5;
  localparam int ST_SLEEP_CNT    = 8;

  // Reset values.
  localparam logic [7:0]  STS_SRC_RST = 8'h20;
  localparam logic [2:0]  SDC_RST     = 3'h0;
  localparam logic        DH_EN_RST   = 1'b0;
  localparam logic [3:0]  AWAKE_RST   = 4'hF;
  localparam logic [3:0]  DHT_RST     = 4'hB;
  localparam logic [10:0] LSL_RST     = 11'h064;
  localparam logic [3:0]  GTT_RST     = 4'h7;
  localparam logic [2:0]  SR_RST      = 3'h0;

  // Key vectors, signal widths and bus answers.
  localparam int KEY_VEC_W = 64;
  localparam int KEY_IDX_W = 6;
  localparam int SIG_W     = 12;
  localparam int GTT_SHIFT = 2;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // UART rates selectable by the serial rate code.
  localparam int BAUD_0 = 9600;
  localparam int BAUD_1 = 19200;
  localparam int BAUD_2 = 38400;
  localparam int BAUD_3 = 57600;
  localparam int BAUD_4 = 115200;

  typedef enum logic {PWR_AWAKE, PWR_ASLEEP} tss_pwr_e;

  typedef struct packed {
    logic [7:0]  sts_src;
    logic [2:0]  sleep_drift_interval;
    logic        dh_en;
    logic [3:0]  awake;
    logic [3:0]  drift_hold_time;
    logic [10:0] lower_signal_limit;
    logic [3:0]  gtt;
    logic [2:0]  sr;
  } tss_cfg_s;

  typedef struct packed {
    logic comm_cmd;
    logic status_read_cmd;
    logic sleep_cmd;
    logic cmd_busy;
  } tss_host_ev_s;

  typedef struct packed {
    logic key_change;
    logic key_release;
    logic any_detect;
    logic any_calib;
    logic any_over_thr;
    logic scan_done;
  } tss_key_ev_s;

  // Maps a 4-bit period code onto a count of 100 ms ticks.
  function automatic logic [7:0] tss_time_lut(input logic [3:0] code);
    logic [7:0] t;
    t = 8'h01;
    case (code)
      4'h0: t = 8'h01;
      4'h1: t = 8'h02;
      4'h2: t = 8'h03;
      4'h3: t = 8'h04;
      4'h4: t = 8'h05;
      4'h5: t = 8'h06;
      4'h6: t = 8'h08;
      4'h7: t = 8'h0A;
      4'h8: t = 8'h0F;
      4'h9: t = 8'h14;
      4'hA: t = 8'h28;
      4'hB: t = 8'h5A;
      4'hC: t = 8'h78;
      4'hD: t = 8'hA0;
      4'hE: t = 8'hC8;
      4'hF: t = 8'hFE;
      default: t = 8'h01;
    endcase
    return t;
  endfunction

  // Gain test threshold: codes 0 to 15 give 4 to 64 in steps of 4.
  function automatic logic [6:0] tss_gtt_value(input logic [3:0] code);
    return 7'(({3'h0, code} + 7'h01) << GTT_SHIFT);
  endfunction

  // Baud divisor for the serial rate code; unused codes fall back to the slowest rate.
  function automatic logic [15:0] tss_baud_div(input logic [2:0] code);
    logic [15:0] d;
    d = 16'(CLK_HZ / BAUD_0);
    case (code)
      3'h1: d = 16'(CLK_HZ / BAUD_1);
      3'h2: d = 16'(CLK_HZ / BAUD_2);
      3'h3: d = 16'(CLK_HZ / BAUD_3);
      3'h4: d = 16'(CLK_HZ / BAUD_4);
      default: d = 16'(CLK_HZ / BAUD_0);
    endcase
    return d;
  endfunction
endpackage
`default_nettype wire

/* logic/tss_housekeeping.sv */
// Sleep, drift hold, signal limit, gain test and status pin housekeeping with its AXI4-Lite registers.
//
// Register access over AXI4-Lite and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module tss_housekeeping
  import tss_pkg::*;
#(
  parameter int NUM_KEYS = 48,
  parameter int BURST_W  = 8,
  parameter int TICK_CYC = TICK_CYC_DEF
) (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic [ADDR_W-1:0]    s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [ADDR_W-1:0]    s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  input  wire tss_key_ev_s          key_ev,
  input  wire tss_host_ev_s         host_ev,
  input  wire logic                 data_ready_line_n,
  input  wire logic                 wake_event,
  input  wire logic                 spi_sck_pin,
  input  wire logic                 spi_ss_n_pin,
  input  wire logic                 ref_valid,
  input  wire logic [KEY_IDX_W-1:0] ref_key,
  input  wire logic [10:0]          ref_level,
  input  wire logic                 gain_valid,
  input  wire logic [KEY_IDX_W-1:0] gain_key,
  input  wire logic                 gain_key_enabled,
  input  wire logic [SIG_W-1:0]     gain_normal,
  input  wire logic [SIG_W-1:0]     gain_test,
  input  wire logic                 gain_test_active,
  input  wire logic [BURST_W-1:0]   burst_len,
  input  wire logic                 debug_frame_done,
  output logic [BURST_W-1:0]        burst_len_used,
  output logic [15:0]               uart_baud_div,
  output logic                      spi_sck_rise,
  output logic                      spi_selected,
  output logic                      sleep_active,
  output logic                      drift_apply,
  output logic                      drift_hold,
  output logic                      debug_frame_start,
  output logic                      scan_hold,
  output logic [KEY_VEC_W-1:0]      key_low_sig_err,
  output logic [KEY_VEC_W-1:0]      gain_test_pass,
  output logic                      sts_out,
  output logic                      sts_oe
);

  tss_cfg_s        cfg_q;
  tss_pwr_e        pwr_q;
  logic            aw_got_q, w_got_q, bvalid_q, rvalid_q;
  logic [7:0]      awaddr_q;
  logic [31:0]     wdata_q, rdata_q;
  logic [3:0]      wstrb_q;
  logic [1:0]      bresp_q, rresp_q;
  logic            do_write;
  logic [31:0]     wr_word;
  logic [TICK_W-1:0] tick_cnt_q;
  logic            tick;
  logic [2:0]      sck_sync_q, ss_sync_q;
  logic            touch_req_q, read_pend_q;
  logic            wd_armed_q, wd_pulse_q, wd_ext_q;
  logic [7:0]      wd_cnt_q;
  logic            sleep_armed_q;
  logic [7:0]      awake_cnt_q, hold_cnt_q;
  logic [5:0]      sleep_cnt_q;
  logic            dbg_busy_q, dbg_start_q, drift_apply_q, sts_act_q;
  logic            sleep_ok;

  // Assembles a register word for reads and for the merge of partial writes.
  function automatic logic [31:0] reg_word(input logic [7:0] a);
    logic [31:0] w;
    w = 32'h0;
    case (a)
      OFF_STS_SRC:    w[7:0] = cfg_q.sts_src;
      OFF_SLEEP_CFG: begin
        w[SDC_LSB +: 3]   = cfg_q.sleep_drift_interval;
        w[DH_EN_BIT]      = cfg_q.dh_en;
        w[AWAKE_LSB +: 4] = cfg_q.awake;
        w[DHT_LSB +: 4]   = cfg_q.drift_hold_time;
      end
      OFF_SIGNAL_CFG: begin
        w[LSL_LSB +: 11] = cfg_q.lower_signal_limit;
        w[GTT_LSB +: 4]  = cfg_q.gtt;
      end
      OFF_SERIAL_CFG: w[SR_LSB +: 3] = cfg_q.sr;
      OFF_STATE: begin
        w[ST_ASLEEP]         = (pwr_q == PWR_ASLEEP);
        w[ST_STS_ACTIVE]     = sts_act_q;
        w[ST_SLEEP_ARMED]    = sleep_armed_q;
        w[ST_WD_ARMED]       = wd_armed_q;
        w[ST_DRIFT_HOLD]     = drift_hold;
        w[ST_DBG_BUSY]       = dbg_busy_q;
        w[ST_SLEEP_CNT +: 6] = sleep_cnt_q;
      end
      OFF_LOW_ERR0:   w = key_low_sig_err[31:0];
      OFF_LOW_ERR1:   w = key_low_sig_err[63:32];
      OFF_GAIN_OK0:   w = gain_test_pass[31:0];
      OFF_GAIN_OK1:   w = gain_test_pass[63:32];
      default:        w = 32'h0;
    endcase
    return w;
  endfunction

  // Tells whether an offset holds a register.
  function automatic logic mapped(input logic [7:0] a);
    return (a == OFF_STS_SRC) || (a == OFF_SLEEP_CFG) || (a == OFF_SIGNAL_CFG) ||
           (a == OFF_SERIAL_CFG) || (a == OFF_STATE) || (a == OFF_LOW_ERR0) ||
           (a == OFF_LOW_ERR1) || (a == OFF_GAIN_OK0) || (a == OFF_GAIN_OK1);
  endfunction

  // Last count value of a sleep interval: 1 << (code - 1) sleeps per compensation.
  function automatic logic [5:0] sdc_last(input logic [2:0] code);
    return 6'((7'h01 << (code - 3'h1)) - 7'h01);
  endfunction

  // Write address and data channels are taken independently and held until the write is done.
  assign s_axi_awready = !aw_got_q;
  assign s_axi_wready  = !w_got_q;
  assign do_write      = aw_got_q && w_got_q && !bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q <= 1'b0;
      awaddr_q <= 8'h00;
    end else if (do_write) begin
      aw_got_q <= 1'b0;
    end else if (s_axi_awvalid && !aw_got_q) begin
      aw_got_q <= 1'b1;
      awaddr_q <= {s_axi_awaddr[ADDR_W-1:2], 2'b00};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_got_q <= 1'b0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
    end else if (do_write) begin
      w_got_q <= 1'b0;
    end else if (s_axi_wvalid && !w_got_q) begin
      w_got_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end
  end

  // Write response follows the write by one cycle; unmapped offsets answer SLVERR.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q  <= mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Read data is registered the cycle after the address is taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0;
      rresp_q  <= RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rdata_q  <= reg_word({s_axi_araddr[ADDR_W-1:2], 2'b00});
      rresp_q  <= mapped({s_axi_araddr[ADDR_W-1:2], 2'b00}) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // Byte-lane merge of the write data into the current register word.
  always_comb begin
    wr_word = reg_word(awaddr_q);
    for (int b = 0; b < 4; b++) begin
      if (wstrb_q[b]) wr_word[8*b +: 8] = wdata_q[8*b +: 8];
    end
  end

  // Configuration registers; status setup defaults to touch report only.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_q.sts_src <= STS_SRC_RST;
      cfg_q.sleep_drift_interval     <= SDC_RST;
      cfg_q.dh_en   <= DH_EN_RST;
      cfg_q.awake   <= AWAKE_RST;
      cfg_q.drift_hold_time     <= DHT_RST;
      cfg_q.lower_signal_limit     <= LSL_RST;
      cfg_q.gtt     <= GTT_RST;
      cfg_q.sr      <= SR_RST;
    end else if (do_write) begin
      case (awaddr_q)
        OFF_STS_SRC:    cfg_q.sts_src <= wr_word[7:0];
        OFF_SLEEP_CFG: begin
          cfg_q.sleep_drift_interval   <= wr_word[SDC_LSB +: 3];
          cfg_q.dh_en <= wr_word[DH_EN_BIT];
          cfg_q.awake <= wr_word[AWAKE_LSB +: 4];
          cfg_q.drift_hold_time   <= wr_word[DHT_LSB +: 4];
        end
        OFF_SIGNAL_CFG: begin
          cfg_q.lower_signal_limit <= wr_word[LSL_LSB +: 11];
          cfg_q.gtt <= wr_word[GTT_LSB +: 4];
        end
        OFF_SERIAL_CFG: cfg_q.sr <= wr_word[SR_LSB +: 3];
        default: ;
      endcase
    end
  end

  // Rate divisor for the UART only; SPI timing never reads it.
  always_ff @(posedge aclk) begin
    if (!aresetn) uart_baud_div <= tss_baud_div(SR_RST);
    else uart_baud_div <= tss_baud_div(cfg_q.sr);
  end

  // SPI pins pass two flip-flops; a third stage finds host clock edges at up to 4 MHz.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sck_sync_q <= 3'h0;
      ss_sync_q  <= 3'h7;
    end else begin
      sck_sync_q <= {sck_sync_q[1:0], spi_sck_pin};
      ss_sync_q  <= {ss_sync_q[1:0], spi_ss_n_pin};
    end
  end
  assign spi_sck_rise = sck_sync_q[1] && !sck_sync_q[2] && !ss_sync_q[1];
  assign spi_selected = !ss_sync_q[1];

  // 100 ms time base; it stops while asleep so all timers freeze.
  always_ff @(posedge aclk) begin
    if (!aresetn) tick_cnt_q <= '0;
    else if (pwr_q == PWR_ASLEEP) tick_cnt_q <= tick_cnt_q;
    else if (tick) tick_cnt_q <= '0;
    else tick_cnt_q <= tick_cnt_q + 1'b1;
  end
  assign tick = (pwr_q == PWR_AWAKE) && (tick_cnt_q == TICK_W'(TICK_CYC - 1));

  // Per-key checks of reference level and of the half-burst gain sample.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      key_low_sig_err <= '0;
      gain_test_pass  <= '0;
      burst_len_used  <= '0;
    end else begin
      burst_len_used <= gain_test_active ? (burst_len >> 1) : burst_len;
      if (ref_valid && (int'(ref_key) < NUM_KEYS)) begin
        key_low_sig_err[ref_key] <= (ref_level < cfg_q.lower_signal_limit);
      end
      if (gain_valid && gain_key_enabled && (int'(gain_key) < NUM_KEYS)) begin
        gain_test_pass[gain_key] <= (gain_normal >= gain_test) &&
          ((gain_normal - gain_test) >= SIG_W'(tss_gtt_value(cfg_q.gtt)));
      end
    end
  end

  // Touch report request: set at reset and on each key change, released at a scan end without detect after a status read.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      touch_req_q <= 1'b1;
      read_pend_q <= 1'b0;
    end else begin
      if (host_ev.status_read_cmd) read_pend_q <= 1'b1;
      else if (key_ev.scan_done) read_pend_q <= 1'b0;
      if (key_ev.key_change) touch_req_q <= 1'b1;
      else if (key_ev.scan_done && read_pend_q && !key_ev.any_detect) touch_req_q <= 1'b0;
    end
  end

  // Host watchdog: arms on the first command, pulses after 2 s silence, extends while commands come.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wd_armed_q <= 1'b0;
      wd_pulse_q <= 1'b0;
      wd_ext_q   <= 1'b0;
      wd_cnt_q   <= 8'h00;
    end else begin
      if (host_ev.comm_cmd) wd_armed_q <= 1'b1;
      if (host_ev.comm_cmd) begin
        wd_cnt_q <= 8'h00;
        if (wd_pulse_q) wd_ext_q <= 1'b1;
      end else if (!wd_armed_q || !cfg_q.sts_src[STS_BIT_RSTHOST]) begin
        wd_cnt_q   <= 8'h00;
        wd_pulse_q <= 1'b0;
        wd_ext_q   <= 1'b0;
      end else if (tick) begin
        if (!wd_pulse_q && (wd_cnt_q == WD_TICKS - 8'h01)) begin
          wd_pulse_q <= 1'b1;
          wd_cnt_q   <= 8'h00;
        end else if (wd_pulse_q && (wd_cnt_q == (wd_ext_q ? WD_TICKS : RST_PULSE_TICKS) - 8'h01)) begin
          wd_pulse_q <= 1'b0;
          wd_ext_q   <= 1'b0;
          wd_cnt_q   <= 8'h00;
        end else begin
          wd_cnt_q <= wd_cnt_q + 8'h01;
        end
      end
    end
  end

  // Status pin: enabled sources ORed, debug left out; pulled low only, held through sleep.
  always_ff @(posedge aclk) begin
    if (!aresetn) sts_act_q <= 1'b0;
    else sts_act_q <= (cfg_q.sts_src[STS_BIT_TOUCH] && touch_req_q) ||
                      (cfg_q.sts_src[STS_BIT_RSTHOST] && wd_pulse_q);
  end
  assign sts_out = 1'b0;
  assign sts_oe  = sts_act_q;

  // Debug stream: one frame per scan, the next scan waits until it is sent.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dbg_busy_q  <= 1'b0;
      dbg_start_q <= 1'b0;
    end else begin
      dbg_start_q <= key_ev.scan_done && cfg_q.sts_src[STS_BIT_DEBUG];
      if (key_ev.scan_done && cfg_q.sts_src[STS_BIT_DEBUG]) dbg_busy_q <= 1'b1;
      else if (debug_frame_done) dbg_busy_q <= 1'b0;
    end
  end
  assign debug_frame_start = dbg_start_q;
  assign scan_hold         = dbg_busy_q;

  // Awake timer restarts at each release and counts down in ticks.
  always_ff @(posedge aclk) begin
    if (!aresetn) awake_cnt_q <= 8'h00;
    else if (key_ev.key_release) awake_cnt_q <= tss_time_lut(cfg_q.awake);
    else if (tick && (awake_cnt_q != 8'h00)) awake_cnt_q <= awake_cnt_q - 8'h01;
  end

  // Sleep is entered at a scan end only when enabled, commanded and nothing keeps the device busy.
  assign sleep_ok = (cfg_q.sleep_drift_interval != 3'h0) && sleep_armed_q && (awake_cnt_q == 8'h00) &&
                    data_ready_line_n && ss_sync_q[1] && !host_ev.cmd_busy && !host_ev.comm_cmd &&
                    !key_ev.any_calib && !key_ev.any_over_thr && !dbg_busy_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) sleep_armed_q <= 1'b0;
    else if (host_ev.sleep_cmd) sleep_armed_q <= 1'b1;
  end

  // Power state and the sleep counter that paces drift compensation.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwr_q         <= PWR_AWAKE;
      sleep_cnt_q   <= 6'h00;
      drift_apply_q <= 1'b0;
    end else begin
      drift_apply_q <= 1'b0;
      unique case (pwr_q)
        PWR_AWAKE: begin
          if (key_ev.scan_done && sleep_ok && !cfg_q.sts_src[STS_BIT_DEBUG]) pwr_q <= PWR_ASLEEP;
        end
        PWR_ASLEEP: begin
          if (wake_event) begin
            pwr_q <= PWR_AWAKE;
            if (sleep_cnt_q >= sdc_last(cfg_q.sleep_drift_interval)) begin
              sleep_cnt_q   <= 6'h00;
              drift_apply_q <= 1'b1;
            end else begin
              sleep_cnt_q <= sleep_cnt_q + 6'h01;
            end
          end
        end
      endcase
    end
  end
  assign sleep_active = (pwr_q == PWR_ASLEEP);
  assign drift_apply  = drift_apply_q;

  // Drift hold timer reloads during any detect and runs out after the last one.
  always_ff @(posedge aclk) begin
    if (!aresetn) hold_cnt_q <= 8'h00;
    else if (key_ev.any_detect) hold_cnt_q <= tss_time_lut(cfg_q.drift_hold_time);
    else if (tick && (hold_cnt_q != 8'h00)) hold_cnt_q <= hold_cnt_q - 8'h01;
  end
  assign drift_hold = cfg_q.dh_en && (key_ev.any_detect || (hold_cnt_q != 8'h00));

endmodule // tss_housekeeping
`default_nettype wire

/* testbench/tss_host_model.sv */
// Host side model that drives the serial select and clock pins.
`timescale 1ns/1ps
`default_nettype none
module tss_host_model (
  input  wire logic frame,
  output logic      sck,
  output logic      ss_n
);
  // Clock runs only while selected.
  initial begin
    sck = 1'b0;
    ss_n = 1'b1;
    #5;
    forever begin
      #32;
      sck = (frame && !ss_n) ? !sck : 1'b0;
      ss_n = !frame;
    end
  end
endmodule // tss_host_model
`default_nettype wire

/* testbench/tss_checker.sv */
// Port checker of the housekeeping block and its bind.
`timescale 1ns/1ps
`default_nettype none
module tss_checker
  import tss_pkg::*;
#(parameter int BURST_W = 8) (
  input wire logic               aclk,
  input wire logic               aresetn,
  input wire tss_key_ev_s        key_ev,
  input wire logic               data_ready_line_n,
  input wire logic               gain_test_active,
  input wire logic [BURST_W-1:0] burst_len,
  input wire logic               debug_frame_done,
  input wire logic [BURST_W-1:0] burst_len_used,
  input wire logic [15:0]        uart_baud_div,
  input wire logic               spi_sck_rise,
  input wire logic               spi_selected,
  input wire logic               sleep_active,
  input wire logic               drift_apply,
  input wire logic               debug_frame_start,
  input wire logic               scan_hold,
  input wire logic               sts_out
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Output rules.
  a_pin_open_drain: assert property (sts_out == 1'b0) else $error("status pin driven high");
  a_baud_table: assert property (uart_baud_div inside {16'h32DC, 16'h196E, 16'h0CB7, 16'h087A, 16'h043D})
    else $error("baud divisor off table");
  a_sck_select: assert property (spi_sck_rise |-> spi_selected) else $error("clock edge while idle");
  a_half_burst: assert property ($past(gain_test_active) |-> burst_len_used == ($past(burst_len) >> 1))
    else $error("test burst not halved");
  a_sleep_gate: assert property ($rose(sleep_active) |-> $past(key_ev.scan_done) && $past(data_ready_line_n)
    && !$past(key_ev.any_calib) && !$past(key_ev.any_over_thr) && !$past(spi_selected)) else $error("bad sleep");
  a_drift_pulse: assert property (drift_apply |-> !sleep_active ##1 !drift_apply) else $error("drift pulse");
  a_dbg_start: assert property (debug_frame_start |-> $past(key_ev.scan_done) && !sleep_active)
    else $error("debug frame without scan");
  a_hold_frame: assert property (scan_hold && !debug_frame_done |=> scan_hold) else $error("hold dropped");
  // Main scenarios.
  c_sleep: cover property ($rose(sleep_active));
  c_drift: cover property (drift_apply);
  c_debug: cover property (debug_frame_start);
endmodule // tss_checker
bind tss_housekeeping tss_checker #(.BURST_W(BURST_W)) u_checker (.*);
`default_nettype wire

/* testbench/testbench.sv */
// Self-checking bench of the housekeeping block with its host model.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import tss_pkg::*;
  logic aclk, aresetn, frame, spi_sck_pin, spi_ss_n_pin, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, data_ready_line_n;
  logic wake_event, ref_valid, gain_valid, gain_key_enabled, gain_test_active, debug_frame_done, spi_sck_rise;
  logic spi_selected, sleep_active, drift_apply, drift_hold, debug_frame_start, scan_hold, sts_out, sts_oe;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, burst_len, burst_len_used;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [3:0]  s_axi_wstrb;
  logic [5:0]  ref_key, gain_key;
  logic [10:0] ref_level;
  logic [11:0] gain_normal, gain_test;
  logic [15:0] uart_baud_div;
  logic [63:0] key_low_sig_err, gain_test_pass;
  logic [15:0] baud [6] = '{16'h32DC, 16'h196E, 16'h0CB7, 16'h087A, 16'h043D, 16'h32DC};
  tss_key_ev_s key_ev;
  tss_host_ev_s host_ev;
  int err_count = 0, cmp_count = 0, n_drift = 0, n_rise = 0, n_pin = 0;
  tss_housekeeping #(.TICK_CYC(10)) DUT (.*);
  tss_host_model u_host (.frame(frame), .sck(spi_sck_pin), .ss_n(spi_ss_n_pin));
  // Clock and event counters.
  initial begin
    aclk = 1'b0;
    forever #4 aclk = !aclk;
  end
  always @(posedge aclk) begin
    n_drift <= n_drift + int'(drift_apply === 1'b1);
    n_rise <= n_rise + int'(spi_sck_rise === 1'b1);
  end
  always @(posedge spi_sck_pin) n_pin <= n_pin + 1;
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic conclude();
    if (err_count == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Bus write and read.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
    logic ok, at, wt;
    logic [1:0] r;
    ok = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!ok) begin
      @(negedge aclk);
      ok = s_axi_bvalid;
      r = s_axi_bresp;
      at = s_axi_awready;
      wt = s_axi_wready;
      @(posedge aclk);
      if (at) s_axi_awvalid <= 1'b0;
      if (wt) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    chk(r, er);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = RESP_OKAY);
    logic ok, at;
    logic [31:0] x;
    logic [1:0] r;
    ok = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!ok) begin
      @(negedge aclk);
      ok = s_axi_rvalid;
      at = s_axi_arready;
      x = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (at) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    chk(x, e);
    chk(r, er);
  endtask
  // Event pulse.
  task automatic pl(input logic [5:0] k, input logic [3:0] h, input logic w, input logic d);
    @(posedge aclk);
    key_ev <= k;
    host_ev <= h;
    wake_event <= w;
    debug_frame_done <= d;
    @(posedge aclk);
    key_ev <= '0;
    host_ev <= '0;
    wake_event <= 1'b0;
    debug_frame_done <= 1'b0;
    repeat (3) @(negedge aclk);
  endtask
  task automatic smp(input logic [5:0] k, input logic en, input logic [11:0] v);
    @(posedge aclk);
    {ref_key, gain_key, gain_key_enabled, ref_level, gain_test} <= {k, k, en, v[10:0], v};
    {ref_valid, gain_valid} <= 2'b11;
    @(posedge aclk);
    {ref_valid, gain_valid} <= 2'b00;
    repeat (2) @(negedge aclk);
  endtask
  // Main sequence.
  initial begin
    {aresetn, frame, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, wake_event} = '0;
    {ref_valid, gain_valid, gain_key_enabled, gain_test_active, debug_frame_done} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, ref_key, gain_key, ref_level, gain_test} = '0;
    key_ev = '0;
    host_ev = '0;
    s_axi_wstrb = 4'hF;
    gain_normal = 12'h064;
    burst_len = 8'h40;
    data_ready_line_n = 1'b1;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(negedge aclk);
    chk(sts_oe, 1'b1);
    rd(OFF_STS_SRC, 32'h20);
    rd(OFF_SLEEP_CFG, 32'hBF0);
    rd(OFF_SIGNAL_CFG, 32'h7064);
    rd(8'hFC, 32'h0, RESP_SLVERR);
    wr(8'hFC, 32'h1, RESP_SLVERR);
    foreach (baud[i]) begin
      wr(OFF_SERIAL_CFG, 32'(i));
      repeat (2) @(negedge aclk);
      chk(uart_baud_div, baud[i]);
    end
    pl(6'h00, 4'h4, 1'b0, 1'b0);
    pl(6'h09, 4'h0, 1'b0, 1'b0);
    chk(sts_oe, 1'b1);
    pl(6'h00, 4'h4, 1'b0, 1'b0);
    pl(6'h01, 4'h0, 1'b0, 1'b0);
    chk(sts_oe, 1'b0);
    pl(6'h20, 4'h0, 1'b0, 1'b0);
    chk(sts_oe, 1'b1);
    wr(OFF_SIGNAL_CFG, 32'h703C);
    gain_test_active <= 1'b1;
    smp(6'd3, 1'b1, 12'd59);
    smp(6'd4, 1'b1, 12'd68);
    smp(6'd5, 1'b1, 12'd69);
    smp(6'd6, 1'b0, 12'd10);
    chk(key_low_sig_err[5:3], 3'b001);
    chk(gain_test_pass[6:3], 4'b0011);
    chk(burst_len_used, 8'h20);
    wr(OFF_SLEEP_CFG, 32'hB02);
    data_ready_line_n <= 1'b0;
    pl(6'h00, 4'h2, 1'b0, 1'b0);
    pl(6'h01, 4'h0, 1'b0, 1'b0);
    chk(sleep_active, 1'b0);
    @(posedge aclk) data_ready_line_n <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      pl(6'h01, 4'h0, 1'b0, 1'b0);
      chk({sleep_active, sts_oe}, 2'b11);
      pl(6'h00, 4'h0, 1'b1, 1'b0);
      chk(n_drift, i);
    end
    wr(OFF_SLEEP_CFG, 32'hBF8);
    wr(OFF_STS_SRC, 32'h80);
    pl(6'h01, 4'h0, 1'b0, 1'b0);
    chk({scan_hold, sts_oe, drift_hold}, 3'b101);
    pl(6'h00, 4'h0, 1'b0, 1'b1);
    chk(scan_hold, 1'b0);
    wr(OFF_STS_SRC, 32'h1);
    pl(6'h00, 4'h8, 1'b0, 1'b0);
    @(posedge sts_oe) pl(6'h00, 4'h8, 1'b0, 1'b0);
    repeat (30) @(negedge aclk);
    chk(sts_oe, 1'b1);
    frame <= 1'b1;
    repeat (40) @(posedge aclk);
    frame <= 1'b0;
    repeat (12) @(negedge aclk);
    chk(n_rise, n_pin);
    conclude();
  end
  // Run time limit.
  initial begin
    repeat (20000) @(posedge aclk);
    err_count++;
    conclude();
  end
endmodule // testbench
`default_nettype wire
